// ### core/dci_pkg.sv
// constants, types and carriers of the disc command interpreter
// assumes one 20 MHz clock and a byte-level bus front end outside
package dci_pkg;
    // ====================================================
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int POLL_US = 100;
    localparam int POLL_CYC = POLL_US * (CLK_HZ / 1_000_000);
    // ====================================================
    // register map (byte offsets)
    localparam logic [4:0] A_STAT = 5'h00;
    localparam logic [4:0] A_CTRL = 5'h04;
    localparam logic [4:0] A_CMD = 5'h08;
    localparam logic [4:0] A_TGT = 5'h0C;
    localparam logic [4:0] A_DEF = 5'h10;
    localparam logic [4:0] A_PAIRS = 5'h14;
    localparam logic [4:0] A_SELF = 5'h18;
    localparam int C_ADV = 0;
    localparam int C_ABT = 1;
    localparam int C_MST = 2;
    localparam int C_DONE = 3;
    localparam int C_RDY = 4;
    localparam int C_FMT = 5;
    localparam int D_VAL = 15;
    // ====================================================
    // completion codes
    localparam logic [1:0] CC_OK = 2'h0;
    localparam logic [1:0] CC_ABORT = 2'h1;
    localparam logic [1:0] CC_HOLD = 2'h2;
    // ====================================================
    // bus bytes, parity stripped
    localparam logic [6:0] P_UNT = 7'h5F;
    localparam logic [6:0] P_UNL = 7'h3F;
    localparam logic [6:0] P_DCL = 7'h14;
    localparam logic [1:0] G_LSN = 2'h1;
    localparam logic [1:0] G_TLK = 2'h2;
    localparam logic [1:0] G_SEC = 2'h3;
    localparam logic [4:0] SC_DATA = 5'h00;
    localparam logic [4:0] SC_DISC = 5'h08;
    localparam logic [4:0] SC_BWR = 5'h09;
    localparam logic [4:0] SC_BRD = 5'h0A;
    localparam logic [4:0] SC_BRV = 5'h0B;
    localparam logic [4:0] SC_PHY = 5'h0C;
    localparam logic [4:0] SC_QRY = 5'h10;
    localparam logic [4:0] SC_LOOP = 5'h1E;
    localparam logic [4:0] SC_SELF = 5'h1F;
    localparam logic [6:0] OP_COLD = 7'h00;
    localparam logic [6:0] OP_SEEK = 7'h02;
    localparam logic [6:0] OP_RSTAT = 7'h03;
    localparam logic [6:0] OP_ADDR = 7'h14;
    localparam logic [2:0] SEEK_LAST = 3'h5;
    // id values are arbitrary
    localparam logic [7:0] ID_BYTE1 = 8'hA1;
    localparam logic [7:0] ID_BYTE2 = 8'hA2;
    localparam logic [7:0] HOLD_BYTE = 8'h01;
    localparam logic [3:0] SECT_LAST = 4'hF;
    localparam logic [6:0] TRK_LAST = 7'h45;
    localparam logic [8:0] LOOP_LAST = 9'h0FF;
    // ====================================================
    // types
    typedef enum logic [2:0] {TX_NONE, TX_QRY, TX_HOLD, TX_ID, TX_STAT, TX_SELF, TX_LOOP} dci_tx_e;
    typedef struct packed {
        logic atn;
        logic eoi;
        logic [7:0] data;
    } dci_rx_s;
    typedef struct packed {
        logic eoi;
        logic [7:0] data;
    } dci_tx_s;
endpackage

// ### core/dci_top.sv
// disc command interpreter: bus byte parser, target counters, holdoff
// assumes a front end that hands over each bus byte with ATN and EOI
module dci_top import dci_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [2:0] own_bus_location_field,
    input wire logic rx_valid,
    input wire dci_rx_s rx,
    output logic rx_ready,
    output logic tx_valid,
    output dci_tx_s tx,
    input wire logic tx_ready,
    output logic poll_reply_offered
);
    // ====================================================
    // state
    typedef struct packed {
        logic [1:0] cc;
        logic lsn;
        logic tlk;
        logic id_arm;
        logic [4:0] sec;
        logic sec_ok;
        logic [6:0] opc;
        logic held;
        logic [2:0] bidx;
        logic [1:0] unit;
        logic [7:0] scyl;
        logic shead;
        logic [3:0][7:0] cyl;
        logic [3:0] head;
        logic [3:0][3:0] sect;
        logic [69:0][15:0] defect;
        logic [69:0] invis;
        logic fmt;
        logic [6:0] ftrk;
        logic dbit;
        logic amode;
        logic poll;
        logic pend;
        logic [4:0] csec;
        logic [6:0] copc;
        logic [15:0] st_two;
        logic [4:0] st_one;
        logic [15:0] selft;
        dci_tx_e txsrc;
        logic [8:0] txidx;
        logic tx_valid;
        dci_tx_s tx;
        logic [7:0] lwp;
        logic ack;
        logic [31:0] rdata;
    } dci_state_s;

    dci_state_s s_q, s_d;
    logic [7:0] loop_mem [256];
    logic loop_we;
    logic [7:0] loop_wa;
    logic rx_take;
    logic [6:0] b7;
    logic match;
    logic we;
    logic [31:0] wd;
    logic do_clr;
    logic lheld;
    logic hnow;
    logic seek_ld;
    logic ld;
    logic [6:0] trk;

    function automatic logic [8:0] last_f(input dci_tx_e src);
        case (src)
            TX_ID, TX_SELF: last_f = 9'h001;
            TX_STAT: last_f = 9'h003;
            TX_LOOP: last_f = LOOP_LAST;
            default: last_f = 9'h000;
        endcase
    endfunction

    assign rx_take = rx_valid & rx_ready;
    assign b7 = rx.data[6:0];
    assign match = b7[4:0] == {2'b00, own_bus_location_field};
    assign we = avs_write & s_q.ack & (avs_byteenable != 4'h0);
    assign wd = avs_writedata;
    // format walk stalls the bus for one pass over the tracks
    assign rx_ready = ~s_q.fmt;
    assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
    assign avs_readdata = s_q.rdata;
    assign tx_valid = s_q.tx_valid;
    assign tx = s_q.tx;
    assign poll_reply_offered = s_q.poll;

    // ====================================================
    // next state
    always_comb begin
        s_d = s_q;
        loop_we = 1'b0;
        loop_wa = s_q.lwp;
        do_clr = 1'b0;
        seek_ld = 1'b0;
        ld = 1'b0;
        trk = {s_q.cyl[s_q.unit][5:0], s_q.head[s_q.unit]};
        lheld = (s_q.sec inside {SC_DISC, SC_BWR, SC_BRD, SC_BRV, SC_PHY})
            && !(s_q.sec == SC_DISC && b7 == OP_COLD);
        hnow = (s_q.bidx == 3'h0) ? (lheld && s_q.cc == CC_HOLD) : s_q.held;
        // talker side: step on each accepted byte
        if (s_q.tx_valid && tx_ready) begin
            if (s_q.txidx == last_f(s_q.txsrc)) begin
                s_d.txsrc = TX_NONE;
            end else begin
                s_d.txidx = s_q.txidx + 9'h001;
                ld = 1'b1;
            end
        end
        if (rx_take && rx.atn) begin
            s_d.txsrc = TX_NONE;
            s_d.id_arm = 1'b0;
            if (b7 == P_DCL) begin
                do_clr = 1'b1;
            end else if (b7 == P_UNT) begin
                s_d.tlk = 1'b0;
                s_d.id_arm = 1'b1;
                if (s_q.tlk && s_q.sec_ok && s_q.sec inside {SC_LOOP, SC_SELF}) begin
                    s_d.poll = 1'b1;
                end
            end else if (b7 == P_UNL) begin
                s_d.lsn = 1'b0;
                if (s_q.lsn && s_q.held) begin
                    s_d.poll = 1'b1;
                end
            end else if (b7[6:5] == G_LSN) begin
                s_d.lsn = s_q.lsn | match;
            end else if (b7[6:5] == G_TLK) begin
                s_d.tlk = match;
            end else if (b7[6:5] == G_SEC) begin
                if (s_q.id_arm && match) begin
                    s_d.txsrc = TX_ID;
                    s_d.txidx = 9'h000;
                    ld = 1'b1;
                end else if (s_q.lsn || s_q.tlk) begin
                    s_d.sec = b7[4:0];
                    s_d.sec_ok = 1'b1;
                    s_d.bidx = 3'h0;
                    s_d.held = 1'b0;
                    s_d.lwp = 8'h00;
                    s_d.poll = 1'b0;
                end
                if (s_q.tlk && !s_q.id_arm) begin
                    s_d.txidx = 9'h000;
                    ld = 1'b1;
                    case (b7[4:0])
                        SC_QRY: begin
                            s_d.txsrc = TX_QRY;
                            if (s_q.cc == CC_HOLD) begin
                                s_d.cc = CC_OK;
                            end
                        end
                        SC_DISC: s_d.txsrc = (s_q.cc == CC_HOLD) ? TX_HOLD : TX_STAT;
                        SC_DATA: s_d.txsrc = (s_q.cc == CC_HOLD) ? TX_HOLD : TX_NONE;
                        SC_LOOP: s_d.txsrc = TX_LOOP;
                        SC_SELF: s_d.txsrc = TX_SELF;
                        default: s_d.txsrc = TX_NONE;
                    endcase
                end
            end
        end else if (rx_take && s_q.lsn && s_q.sec_ok) begin
            if (s_q.bidx != 3'h7) begin
                s_d.bidx = s_q.bidx + 3'h1;
            end
            if (s_q.bidx == 3'h0) begin
                s_d.opc = b7;
                s_d.held = hnow;
            end
            // held bytes are handshaken and dropped
            if (hnow) begin
                s_d.held = 1'b1;
            end else if (s_q.sec == SC_QRY) begin
                do_clr = 1'b1;
            end else if (s_q.sec == SC_SELF) begin
                s_d.cc = CC_HOLD;
            end else if (s_q.sec == SC_LOOP) begin
                loop_we = 1'b1;
                s_d.lwp = s_q.lwp + 8'h01;
            end else if (s_q.bidx == 3'h1 && s_q.cc != CC_HOLD) begin
                s_d.unit = rx.data[1:0];
                s_d.amode = s_q.opc == OP_ADDR;
                if (s_q.opc != OP_SEEK && s_q.opc != OP_RSTAT && s_q.opc != OP_ADDR) begin
                    s_d.pend = 1'b1;
                    s_d.csec = s_q.sec;
                    s_d.copc = s_q.opc;
                end
            end else if (s_q.opc == OP_SEEK && s_q.cc != CC_HOLD) begin
                if (s_q.bidx == 3'h3) begin
                    s_d.scyl = rx.data;
                end
                if (s_q.bidx == 3'h4) begin
                    s_d.shead = rx.data[0];
                end
                if (s_q.bidx == SEEK_LAST) begin
                    seek_ld = 1'b1;
                    s_d.cyl[s_q.unit] = s_q.scyl;
                    s_d.head[s_q.unit] = s_q.shead;
                    s_d.sect[s_q.unit] = rx.data[3:0];
                end
            end
        end
        if (do_clr) begin
            s_d.cc = CC_OK;
            s_d.dbit = 1'b0;
            for (int u = 0; u < 4; u++) begin
                s_d.cyl[u] = 8'h00;
                s_d.head[u] = 1'b0;
                s_d.sect[u] = 4'h0;
            end
        end
        // format pass: one track per cycle
        if (s_q.fmt) begin
            s_d.invis[s_q.ftrk] = |s_q.defect[s_q.ftrk];
            s_d.ftrk = s_q.ftrk + 7'h01;
            if (s_q.ftrk == TRK_LAST) begin
                s_d.fmt = 1'b0;
            end
        end
        // ------------------------------------------------
        // register writes; software settles last
        if (we) begin
            case (avs_address)
                A_CTRL: begin
                    if (wd[C_ADV] && !wd[C_ABT]) begin
                        if (trk <= TRK_LAST && s_q.defect[trk][s_q.sect[s_q.unit]]) begin
                            s_d.dbit = 1'b1;
                        end
                        s_d.sect[s_q.unit] = s_q.sect[s_q.unit] + 4'h1;
                        if (s_q.sect[s_q.unit] == SECT_LAST) begin
                            s_d.head[s_q.unit] = ~s_q.head[s_q.unit];
                            if (s_q.head[s_q.unit]) begin
                                s_d.cyl[s_q.unit] = s_q.cyl[s_q.unit] + 8'h01;
                            end
                        end
                    end
                    if (wd[C_ABT]) begin
                        s_d.cc = CC_ABORT;
                    end
                    if (wd[C_DONE]) begin
                        s_d.cc = CC_OK;
                    end
                    if (wd[C_MST]) begin
                        s_d.cc = CC_HOLD;
                    end
                    if (wd[C_RDY]) begin
                        s_d.poll = 1'b1;
                    end
                    if (wd[C_FMT] && !s_q.fmt) begin
                        s_d.fmt = 1'b1;
                        s_d.ftrk = 7'h00;
                    end
                end
                A_CMD: begin
                    // a command posted in this cycle survives the clear only if none was pending before
                    if (wd[0] && !(s_d.pend && !s_q.pend)) begin
                        s_d.pend = 1'b0;
                    end
                end
                A_DEF: begin
                    if (wd[14:8] <= TRK_LAST) begin
                        s_d.defect[wd[14:8]][wd[3:0]] = wd[D_VAL];
                    end
                end
                A_PAIRS: begin
                    s_d.st_two = wd[15:0];
                    s_d.st_one = wd[20:16];
                end
                A_SELF: s_d.selft = wd[15:0];
                default: ;
            endcase
        end
        // ------------------------------------------------
        // talker byte load
        s_d.tx_valid = s_d.txsrc != TX_NONE;
        if (ld) begin
            s_d.tx.eoi = s_d.txidx == last_f(s_d.txsrc);
            case (s_d.txsrc)
                TX_QRY: s_d.tx.data = {6'h00, s_q.cc};
                TX_HOLD: s_d.tx.data = HOLD_BYTE;
                TX_ID: s_d.tx.data = s_d.txidx[0] ? ID_BYTE2 : ID_BYTE1;
                TX_SELF: s_d.tx.data = s_d.txidx[0] ? s_q.selft[7:0] : s_q.selft[15:8];
                TX_LOOP: s_d.tx.data = loop_mem[s_d.txidx[7:0]];
                TX_STAT: begin
                    case (s_d.txidx[1:0])
                        2'h0: s_d.tx.data = s_q.amode ? 8'h00 : {2'b00, s_q.dbit, s_q.st_one};
                        2'h1: s_d.tx.data = s_q.amode ? s_q.cyl[s_q.unit] : {6'h00, s_q.unit};
                        2'h2: s_d.tx.data = s_q.amode ? {7'h00, s_q.head[s_q.unit]} : s_q.st_two[15:8];
                        default: s_d.tx.data = s_q.amode ? {4'h0, s_q.sect[s_q.unit]} : s_q.st_two[7:0];
                    endcase
                end
                default: s_d.tx.data = 8'h00;
            endcase
        end
        // ------------------------------------------------
        // bus slave: one wait cycle, read data from a flop
        s_d.ack = (avs_read | avs_write) & ~s_q.ack;
        if (avs_read && !s_q.ack) begin
            case (avs_address)
                A_STAT: s_d.rdata = {25'h0, s_q.unit, s_q.dbit, s_q.cc == CC_HOLD, s_q.poll, s_q.cc};
                A_CMD: s_d.rdata = {5'h00, s_q.unit, 2'b00, s_q.copc, 3'h0, s_q.csec, 7'h00, s_q.pend};
                A_TGT: s_d.rdata = {8'h00, s_q.cyl[s_q.unit], 7'h00, s_q.head[s_q.unit], 4'h0,
                    s_q.sect[s_q.unit]};
                A_DEF: s_d.rdata = {29'h0, s_q.fmt, trk <= TRK_LAST && s_q.invis[trk],
                    trk <= TRK_LAST && s_q.defect[trk][s_q.sect[s_q.unit]]};
                A_PAIRS: s_d.rdata = {11'h000, s_q.st_one, s_q.st_two};
                A_SELF: s_d.rdata = {16'h0000, s_q.selft};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ====================================================
    // registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.cc <= CC_HOLD;
            s_q.txsrc <= TX_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (loop_we) begin
            loop_mem[loop_wa] <= rx.data;
        end
    end

    // ====================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic sec_take;
    assign sec_take = rx_take && rx.atn && b7[6:5] == G_SEC && (s_q.lsn || s_q.tlk) && !s_q.id_arm;
    logic adv_wr;
    assign adv_wr = we && avs_address == A_CTRL && wd[C_ADV] && !wd[C_ABT] && !wd[C_MST];

    property p_clear;
        rx_take && rx.atn && b7 == P_DCL && !we
        |=> s_q.cc == CC_OK && s_q.cyl[3] == 8'h00 && s_q.head[3] == 1'b0 && s_q.sect[3] == 4'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left target or code set");

    property p_seek;
        seek_ld && !we |=> s_q.sect[s_q.unit] == $past(rx.data[3:0]) && s_q.cyl[s_q.unit] == $past(s_q.scyl);
    endproperty
    a_seek: assert property (p_seek) else $error("seek did not load target");

    property p_wrap;
        adv_wr && s_q.sect[s_q.unit] == SECT_LAST && s_q.head[s_q.unit]
        |=> s_q.sect[s_q.unit] == 4'h0 && !s_q.head[s_q.unit]
            && s_q.cyl[s_q.unit] == $past(s_q.cyl[s_q.unit]) + 8'h01;
    endproperty
    a_wrap: assert property (p_wrap) else $error("cylinder wrap wrong");

    property p_abort;
        we && avs_address == A_CTRL && wd[C_ABT] && !wd[C_MST] && !wd[C_DONE] && !seek_ld && !do_clr
        |=> s_q.cc == CC_ABORT && $stable(s_q.sect) && $stable(s_q.cyl);
    endproperty
    a_abort: assert property (p_abort) else $error("abort moved target");

    property p_selftest;
        we && avs_address == A_CTRL && wd[C_MST] |=> s_q.cc == CC_HOLD;
    endproperty
    a_selftest: assert property (p_selftest) else $error("selftest did not hold off");

    property p_holdoff;
        s_q.cc == CC_HOLD && !s_q.pend |=> !s_q.pend;
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("command posted in holdoff");

    property p_hold_talk;
        sec_take && s_q.tlk && s_q.cc == CC_HOLD && b7[4:0] == SC_DISC
        |=> s_q.tx_valid && s_q.tx.data == HOLD_BYTE && s_q.tx.eoi;
    endproperty
    a_hold_talk: assert property (p_hold_talk) else $error("held talk byte wrong");

    sequence s_id_start;
        rx_take && rx.atn && s_q.id_arm && b7[6:5] == G_SEC && match;
    endsequence
    sequence s_id_first;
        tx_valid && tx.data == ID_BYTE1 && !tx.eoi;
    endsequence
    // the far end may take its time, so the second byte is keyed on the accept
    sequence s_id_first_taken;
        s_id_first ##0 (tx_ready && !rx_take && s_q.txsrc == TX_ID);
    endsequence
    sequence s_id_second;
        tx_valid && tx.data == ID_BYTE2 && tx.eoi;
    endsequence
    property p_ident;
        s_id_start |=> s_id_first;
    endproperty
    a_ident: assert property (p_ident) else $error("identify bytes wrong");

    property p_ident_second;
        s_id_first_taken |=> s_id_second;
    endproperty
    a_ident_second: assert property (p_ident_second) else $error("second identify byte wrong");

    property p_poll;
        sec_take && !we |=> !poll_reply_offered;
    endproperty
    a_poll: assert property (p_poll) else $error("poll reply not withdrawn");
endmodule // dci_top

// ### testbench/dci_bus_ctl_model.sv
// bus controller model: sends command bytes, takes talker bytes
// assumes byte-level handshakes on the rising edge of core_clk
module dci_bus_ctl_model import dci_pkg::*; (
    input wire logic core_clk,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire dci_tx_s tx,
    output logic rx_valid,
    output dci_rx_s rx,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // idle state
    initial begin
        rx_valid = 1'b0;
        rx = '0;
        tx_ready = 1'b0;
    end
    // ==========================================
    // one byte towards the device, held until taken
    task automatic send(input logic a, input logic e, input logic [7:0] d);
        logic ok;
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx <= '{atn: a, eoi: e, data: d};
        do begin
            @(negedge core_clk);
            ok = rx_ready;
            @(posedge core_clk);
        end while (!ok);
        rx_valid <= 1'b0;
        // released lines show the inverse, not a stale copy
        rx.data <= ~d;
    endtask
    // ==========================================
    // one byte from the device
    task automatic recv(output logic [8:0] b);
        logic ok;
        @(posedge core_clk);
        tx_ready <= 1'b1;
        do begin
            @(negedge core_clk);
            ok = tx_valid;
            b = {tx.eoi, tx.data};
            @(posedge core_clk);
        end while (!ok);
        tx_ready <= 1'b0;
    endtask
endmodule // dci_bus_ctl_model

// ### testbench/test_dci_top.sv
// self-checking bench of the disc command interpreter
// assumes the bus controller model and a bus address switch of 5
module test_dci_top;
    import dci_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst, avs_read, avs_write, avs_waitrequest, rx_valid, rx_ready;
    logic tx_valid, tx_ready, poll_reply_offered;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [3:0] avs_byteenable;
    logic [8:0] b;
    dci_rx_s rx;
    dci_tx_s tx;
    int errors = 0, checks = 0, cycles = 0;
    dci_top i_dci_top (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .own_bus_location_field(3'h5),
        .rx_valid(rx_valid), .rx(rx), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx(tx),
        .tx_ready(tx_ready), .poll_reply_offered(poll_reply_offered));
    dci_bus_ctl_model i_dci_bus_ctl_model (.core_clk(core_clk), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx(tx), .rx_valid(rx_valid), .rx(rx), .tx_ready(tx_ready));
    // ==========================================
    // clock, timeout, verdict
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // ==========================================
    // register bus
    task automatic avs_rd(input logic [4:0] a, output logic [31:0] q);
        logic w;
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do begin
            @(negedge core_clk);
            w = avs_waitrequest;
            q = avs_readdata;
            @(posedge core_clk);
        end while (w);
        avs_read <= 1'b0;
    endtask
    task automatic avs_wr(input logic [4:0] a, input logic [31:0] v);
        logic w;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do begin
            @(negedge core_clk);
            w = avs_waitrequest;
            @(posedge core_clk);
        end while (w);
        avs_write <= 1'b0;
    endtask
    // listen, secondary, two data bytes with eoi on the last, unlisten
    task automatic lsn_seq(input logic [7:0] sc, input logic [7:0] b0, input logic [7:0] b1);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h25);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, sc);
        i_dci_bus_ctl_model.send(1'b0, 1'b0, b0);
        i_dci_bus_ctl_model.send(1'b0, 1'b1, b1);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h3F);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        avs_rd(A_STAT, d);
        chk(d[3:0], {2'h2, CC_HOLD});
        avs_rd(A_TGT, d);
        chk(d, 32'h0);
    endtask
    task automatic t_held();
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h45);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h68);
        i_dci_bus_ctl_model.recv(b);
        chk(b, {1'b1, HOLD_BYTE});
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h5F);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h25);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h6B);
        i_dci_bus_ctl_model.send(1'b0, 1'b0, 8'h05);
        i_dci_bus_ctl_model.send(1'b0, 1'b1, 8'h00);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h3F);
        avs_rd(A_CMD, d);
        chk(d[0], 1'b0);
    endtask
    // controller learns of the power loss by querying the code
    task automatic t_query();
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h45);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'hF0);
        i_dci_bus_ctl_model.recv(b);
        chk(b, 9'h102);
        chk(poll_reply_offered, 1'b0);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h5F);
        avs_rd(A_STAT, d);
        chk(d[1:0], CC_OK);
    endtask
    task automatic t_ident();
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'hDF);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h65);
        i_dci_bus_ctl_model.recv(b);
        chk(b, {1'b0, ID_BYTE1});
        i_dci_bus_ctl_model.recv(b);
        chk(b, {1'b1, ID_BYTE2});
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h3F);
    endtask
    task automatic t_seek();
        logic [7:0] p [6] = '{8'h02, 8'h01, 8'h00, 8'h03, 8'h01, 8'h0F};
        logic [7:0] st [4] = '{8'h12, 8'h00, 8'h34, 8'h56};
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h25);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h68);
        for (int i = 0; i < 6; i++) begin
            i_dci_bus_ctl_model.send(1'b0, i == 5, p[i]);
        end
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h3F);
        avs_rd(A_TGT, d);
        chk(d, 32'h0003_010F);
        avs_wr(A_PAIRS, 32'h0012_3456);
        lsn_seq(8'h68, 8'h03, 8'h00);
        avs_rd(A_TGT, d);
        chk(d, 32'h0);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h45);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h68);
        for (int i = 0; i < 4; i++) begin
            i_dci_bus_ctl_model.recv(b);
            chk(b, {i == 3, st[i]});
        end
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h5F);
        lsn_seq(8'h68, 8'h03, 8'h01);
        avs_wr(A_CTRL, 32'h1);
        avs_rd(A_TGT, d);
        chk(d, 32'h0004_0000);
        avs_wr(A_CTRL, 32'h2);
        avs_rd(A_TGT, d);
        chk(d, 32'h0004_0000);
        avs_rd(A_STAT, d);
        chk(d[1:0], CC_ABORT);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h14);
        avs_rd(A_TGT, d);
        chk(d, 32'h0);
    endtask
    task automatic t_defect();
        avs_wr(A_DEF, 32'h0000_8000);
        avs_rd(A_DEF, d);
        chk(d, 32'h1);
        avs_wr(A_CTRL, 32'h20);
        avs_rd(A_DEF, d);
        chk(d, 32'h7);
        chk(rx_ready, 1'b0);
        repeat (80) @(posedge core_clk);
        avs_rd(A_DEF, d);
        chk(d, 32'h3);
        chk(rx_ready, 1'b1);
        avs_wr(A_CTRL, 32'h1);
        avs_rd(A_STAT, d);
        chk(d[4], 1'b1);
    endtask
    // loopback runs in holdoff, then the listen clear ends it
    task automatic t_loop();
        avs_wr(A_CTRL, 32'h4);
        avs_rd(A_STAT, d);
        chk(d[1:0], CC_HOLD);
        lsn_seq(8'h7E, 8'h5A, 8'hC3);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h45);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h7E);
        i_dci_bus_ctl_model.recv(b);
        chk(b, 9'h05A);
        i_dci_bus_ctl_model.recv(b);
        chk(b, 9'h0C3);
        i_dci_bus_ctl_model.send(1'b1, 1'b0, 8'h5F);
        avs_rd(A_STAT, d);
        chk(d[2], 1'b1);
        lsn_seq(8'h70, 8'h00, 8'h00);
        avs_rd(A_STAT, d);
        chk(d[1:0], CC_OK);
    endtask
    // ==========================================
    // main sequence
    initial begin
        rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_held();
        t_query();
        t_ident();
        t_seek();
        t_defect();
        t_loop();
        print_verdict();
    end
endmodule // test_dci_top
